//--- config_word_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module config_word_decoder
#(
	parameter int unsigned ADDR_W = config_word_pkg::ADDR_W,
	parameter int unsigned WORD_W = config_word_pkg::WORD_W
)
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// Register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [WORD_W-1:0] regWrData,
	input  wire logic              regWrStrobe,
	input  wire logic              regRdStrobe,
	output logic      [WORD_W-1:0] regRdData,
	// Words from programmed memory, same clock
	input  wire logic [WORD_W-1:0] nvmWordOne,
	input  wire logic [WORD_W-1:0] nvmWordTwo,
	input  wire logic              nvmLoadStrobe,
	// Core state, same clock
	input  wire logic              coreSleep,
	// Decoded controls
	output logic                   configReady,
	output logic                   clockOutDrive,
	output logic                   clockOutPinIsIo,
	output logic                   clockOutPinIsOsc,
	output logic                   brownoutActive,
	output logic                   dataReadProtect,
	output logic                   progReadProtect,
	output logic                   resetPinEnable,
	output logic                   powerupTimerEnable,
	output logic                   watchdogRun,
	output logic                   outsideClockSel,
	output logic                   onChipOscSel,
	output logic                   rcOscSel,
	output logic                   crystalSel,
	output logic      [1:0]        oscDriveLevel,
	output logic                   clockInPinIsIo,
	output logic                   lowVoltageProgram,
	output logic                   debuggerEnable,
	output logic                   brownoutLevelSelect,
	output logic                   stackFaultResetEnable,
	output logic                   freqMultiplierEnable,
	output logic      [1:0]        flashGuard
);

	// ----------------------------------------------------------------
	// Shared decode
	// ----------------------------------------------------------------
	// One policy table serves brown-out and watchdog alike
	function automatic logic policyActive(input logic [1:0] field,
	                                      input logic       asleep,
	                                      input logic       swEnable);
		logic result;
		result = 1'b0;
		unique case (config_word_pkg::enable_policy_e'(field))
			config_word_pkg::POLICY_ALWAYS:   result = 1'b1;
			config_word_pkg::POLICY_RUN_ONLY: result = ~asleep;
			config_word_pkg::POLICY_SOFTWARE: result = swEnable;
			config_word_pkg::POLICY_OFF:      result = 1'b0;
		endcase
		return result;
	endfunction : policyActive

	function automatic logic isCrystal(input logic [2:0] sel);
		return (sel == config_word_pkg::OSC_LOW_POWER_CRYSTAL)
		    || (sel == config_word_pkg::OSC_STANDARD_CRYSTAL)
		    || (sel == config_word_pkg::OSC_HIGH_SPEED_CRYSTAL);
	endfunction : isCrystal

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	config_word_pkg::load_state_e loadState_r;
	config_word_pkg::load_state_e loadState_nxt;

	logic [WORD_W-1:0] wordOne_r;
	logic [WORD_W-1:0] wordTwo_r;
	logic              swBrownoutEn_r;
	logic              swWatchdogEn_r;
	logic [WORD_W-1:0] rdData_nxt;

	logic              wrWordOne;
	logic              wrWordTwo;
	logic              wrBrownout;
	logic              wrWatchdog;

	logic [2:0]        oscillatorSelect;
	logic [1:0]        brownoutField;
	logic [1:0]        watchdogField;
	logic              clockOutEnableBit;
	logic              crystalMode;

	logic              decOutside;
	logic              decOnChip;
	logic              decRc;
	logic              decCrystal;
	logic [1:0]        decDrive;
	logic              decClockInIo;

	logic [WORD_W-1:0] statusWord;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wrWordOne  = regWrStrobe && (regAddr == config_word_pkg::REG_WORD_ONE);
	assign wrWordTwo  = regWrStrobe && (regAddr == config_word_pkg::REG_WORD_TWO);
	assign wrBrownout = regWrStrobe && (regAddr == config_word_pkg::REG_BROWNOUT);
	assign wrWatchdog = regWrStrobe && (regAddr == config_word_pkg::REG_WATCHDOG);

	// ----------------------------------------------------------------
	// Load sequence
	// ----------------------------------------------------------------
	// Only configReady waits for the first load; decoded outputs follow the word registers from the first edge after reset
	always_comb
	begin
		loadState_nxt = loadState_r;
		unique case (loadState_r)
			config_word_pkg::LOAD_WAIT:
			begin
				if (nvmLoadStrobe)
				begin
					loadState_nxt = config_word_pkg::LOAD_DONE;
				end
			end
			config_word_pkg::LOAD_DONE:
			begin
				loadState_nxt = config_word_pkg::LOAD_DONE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			loadState_r <= config_word_pkg::LOAD_WAIT;
		end
		else
		begin
			loadState_r <= loadState_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Configuration words
	// ----------------------------------------------------------------
	// Memory load wins over a register write in the same cycle,
	// since the programmed contents are the authority.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wordOne_r <= config_word_pkg::WORD_ONE_ERASED;
		end
		else if (nvmLoadStrobe)
		begin
			wordOne_r <= nvmWordOne;
		end
		else if (wrWordOne)
		begin
			wordOne_r <= regWrData;
		end
	end

	// Unimplemented bits of the second word other than bit 4 stay at one
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wordTwo_r <= config_word_pkg::WORD_TWO_ERASED;
		end
		else if (nvmLoadStrobe)
		begin
			wordTwo_r <= nvmWordTwo | config_word_pkg::WORD_TWO_ONES;
		end
		else if (wrWordTwo)
		begin
			wordTwo_r <= regWrData | config_word_pkg::WORD_TWO_ONES;
		end
	end

	// ----------------------------------------------------------------
	// Software enable bits
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			swBrownoutEn_r <= config_word_pkg::SW_ENABLE_RESET;
		end
		else if (wrBrownout)
		begin
			swBrownoutEn_r <= regWrData[config_word_pkg::SW_ENABLE_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			swWatchdogEn_r <= config_word_pkg::SW_ENABLE_RESET;
		end
		else if (wrWatchdog)
		begin
			swWatchdogEn_r <= regWrData[config_word_pkg::SW_ENABLE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	assign oscillatorSelect  = wordOne_r[config_word_pkg::OSC_SEL_LSB +: 3];
	assign brownoutField     = wordOne_r[config_word_pkg::BROWNOUT_LSB +: 2];
	assign watchdogField     = wordOne_r[config_word_pkg::WATCHDOG_LSB +: 2];
	assign clockOutEnableBit = wordOne_r[config_word_pkg::CLK_OUT_EN_BIT];
	assign crystalMode       = isCrystal(oscillatorSelect);

	osc_source_decoder osc_source_decoder_inst
	(
		.oscillatorSelect (oscillatorSelect),
		.outsideClockSel  (decOutside),
		.onChipOscSel     (decOnChip),
		.rcOscSel         (decRc),
		.crystalSel       (decCrystal),
		.driveLevel       (decDrive),
		.clockInPinIsIo   (decClockInIo)
	);

	// ----------------------------------------------------------------
	// Clock-out pin
	// ----------------------------------------------------------------
	// Crystal modes need the pin for the oscillator, so the enable bit
	// has no say there.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clockOutDrive    <= 1'b0;
			clockOutPinIsIo  <= 1'b0;
			clockOutPinIsOsc <= 1'b0;
		end
		else if (crystalMode)
		begin
			clockOutDrive    <= 1'b0;
			clockOutPinIsIo  <= 1'b0;
			clockOutPinIsOsc <= 1'b1;
		end
		else
		begin
			clockOutDrive    <= ~clockOutEnableBit;
			clockOutPinIsIo  <= clockOutEnableBit;
			clockOutPinIsOsc <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Brown-out and watchdog enables
	// ----------------------------------------------------------------
	// One cycle behind a Sleep change; both blocks tolerate that.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			brownoutActive <= 1'b0;
		end
		else
		begin
			brownoutActive <= policyActive(brownoutField, coreSleep, swBrownoutEn_r);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			watchdogRun <= 1'b0;
		end
		else
		begin
			watchdogRun <= policyActive(watchdogField, coreSleep, swWatchdogEn_r);
		end
	end

	// ----------------------------------------------------------------
	// Protection and power-up timer
	// ----------------------------------------------------------------
	// Reset sets protection on only until the first edge, which decodes the erased word
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dataReadProtect    <= 1'b1;
			progReadProtect    <= 1'b1;
			powerupTimerEnable <= 1'b0;
			resetPinEnable     <= 1'b1;
		end
		else
		begin
			dataReadProtect    <= ~wordOne_r[config_word_pkg::DATA_PROT_BIT];
			progReadProtect    <= ~wordOne_r[config_word_pkg::PROG_PROT_BIT];
			powerupTimerEnable <= ~wordOne_r[config_word_pkg::PWRUP_TIMER_BIT];
			resetPinEnable     <= wordOne_r[config_word_pkg::RESET_PIN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Clock source
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			outsideClockSel <= 1'b0;
			onChipOscSel    <= 1'b0;
			rcOscSel        <= 1'b0;
			crystalSel      <= 1'b0;
			oscDriveLevel   <= config_word_pkg::DRIVE_LOW;
			clockInPinIsIo  <= 1'b0;
		end
		else
		begin
			outsideClockSel <= decOutside;
			onChipOscSel    <= decOnChip;
			rcOscSel        <= decRc;
			crystalSel      <= decCrystal;
			oscDriveLevel   <= decDrive;
			clockInPinIsIo  <= decClockInIo;
		end
	end

	// ----------------------------------------------------------------
	// Second word fields
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lowVoltageProgram     <= 1'b1;
			debuggerEnable        <= 1'b0;
			brownoutLevelSelect   <= 1'b1;
			stackFaultResetEnable <= 1'b1;
			freqMultiplierEnable  <= 1'b1;
			flashGuard            <= 2'h3;
		end
		else
		begin
			lowVoltageProgram     <= wordTwo_r[config_word_pkg::LOW_VOLT_PROG_BIT];
			debuggerEnable        <= ~wordTwo_r[config_word_pkg::DEBUGGER_BIT];
			brownoutLevelSelect   <= wordTwo_r[config_word_pkg::BROWNOUT_LVL_BIT];
			stackFaultResetEnable <= wordTwo_r[config_word_pkg::STACK_FAULT_BIT];
			freqMultiplierEnable  <= wordTwo_r[config_word_pkg::FREQ_MULT_BIT];
			flashGuard            <= wordTwo_r[config_word_pkg::FLASH_GUARD_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			configReady <= 1'b0;
		end
		else
		begin
			configReady <= (loadState_r == config_word_pkg::LOAD_DONE);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb
	begin
		statusWord = config_word_pkg::READ_ZERO;
		statusWord[config_word_pkg::ST_BROWNOUT_BIT]  = brownoutActive;
		statusWord[config_word_pkg::ST_WATCHDOG_BIT]  = watchdogRun;
		statusWord[config_word_pkg::ST_DATA_PROT_BIT] = dataReadProtect;
		statusWord[config_word_pkg::ST_PROG_PROT_BIT] = progReadProtect;
		statusWord[config_word_pkg::ST_PWRUP_BIT]     = powerupTimerEnable;
		statusWord[config_word_pkg::ST_CLK_OUT_BIT]   = clockOutDrive;
		statusWord[config_word_pkg::ST_READY_BIT]     = configReady;
		statusWord[config_word_pkg::ST_OSC_LSB +: 3]  = oscillatorSelect;
	end

	always_comb
	begin
		rdData_nxt = config_word_pkg::READ_ZERO;
		if (regRdStrobe)
		begin
			unique case (regAddr)
				config_word_pkg::REG_WORD_ONE: rdData_nxt = wordOne_r;
				config_word_pkg::REG_WORD_TWO: rdData_nxt = wordTwo_r;
				config_word_pkg::REG_BROWNOUT:
					rdData_nxt[config_word_pkg::SW_ENABLE_BIT] = swBrownoutEn_r;
				config_word_pkg::REG_WATCHDOG:
					rdData_nxt[config_word_pkg::SW_ENABLE_BIT] = swWatchdogEn_r;
				config_word_pkg::REG_STATUS:   rdData_nxt = statusWord;
				default:                       rdData_nxt = config_word_pkg::READ_ZERO;
			endcase
		end
	end

	// Data stand one cycle after the strobe and are zero otherwise
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			regRdData <= config_word_pkg::READ_ZERO;
		end
		else
		begin
			regRdData <= rdData_nxt;
		end
	end

endmodule : config_word_decoder

`default_nettype wire

//--- config_word_pkg.sv
package config_word_pkg;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned WORD_W = 14;

	localparam logic [ADDR_W-1:0] REG_WORD_ONE  = 4'h0;
	localparam logic [ADDR_W-1:0] REG_WORD_TWO  = 4'h1;
	localparam logic [ADDR_W-1:0] REG_BROWNOUT  = 4'h2;
	localparam logic [ADDR_W-1:0] REG_WATCHDOG  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h4;

	localparam logic [WORD_W-1:0] READ_ZERO     = 14'h0000;

	// ----------------------------------------------------------------
	// First configuration word layout
	// ----------------------------------------------------------------
	localparam int unsigned CLK_OUT_EN_BIT    = 11;
	localparam int unsigned BROWNOUT_LSB      = 9;
	localparam int unsigned DATA_PROT_BIT     = 8;
	localparam int unsigned PROG_PROT_BIT     = 7;
	localparam int unsigned RESET_PIN_BIT     = 6;
	localparam int unsigned PWRUP_TIMER_BIT   = 5;
	localparam int unsigned WATCHDOG_LSB      = 3;
	localparam int unsigned OSC_SEL_LSB       = 0;

	// ----------------------------------------------------------------
	// Second configuration word layout
	// ----------------------------------------------------------------
	localparam int unsigned LOW_VOLT_PROG_BIT = 13;
	localparam int unsigned DEBUGGER_BIT      = 12;
	localparam int unsigned BROWNOUT_LVL_BIT  = 10;
	localparam int unsigned STACK_FAULT_BIT   = 9;
	localparam int unsigned FREQ_MULT_BIT     = 8;
	localparam int unsigned FLASH_GUARD_LSB   = 0;

	// Erased state, and unimplemented bits that always read one (bit 4 of the second word is unused but not forced)
	localparam logic [WORD_W-1:0] WORD_ONE_ERASED = 14'h3FFF;
	localparam logic [WORD_W-1:0] WORD_TWO_ERASED = 14'h3FFF;
	localparam logic [WORD_W-1:0] WORD_TWO_ONES   = 14'h08EC;

	// ----------------------------------------------------------------
	// Software control registers and status
	// ----------------------------------------------------------------
	localparam int unsigned SW_ENABLE_BIT     = 0;
	localparam logic        SW_ENABLE_RESET   = 1'b0;

	localparam int unsigned ST_BROWNOUT_BIT   = 0;
	localparam int unsigned ST_WATCHDOG_BIT   = 1;
	localparam int unsigned ST_DATA_PROT_BIT  = 2;
	localparam int unsigned ST_PROG_PROT_BIT  = 3;
	localparam int unsigned ST_PWRUP_BIT      = 4;
	localparam int unsigned ST_CLK_OUT_BIT    = 5;
	localparam int unsigned ST_READY_BIT      = 6;
	localparam int unsigned ST_OSC_LSB        = 7;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OSC_LOW_POWER_CRYSTAL   = 3'h0,
		OSC_STANDARD_CRYSTAL    = 3'h1,
		OSC_HIGH_SPEED_CRYSTAL  = 3'h2,
		OSC_RESISTOR_CAPACITOR  = 3'h3,
		OSC_ON_CHIP             = 3'h4,
		OSC_OUTSIDE_LOW_POWER   = 3'h5,
		OSC_OUTSIDE_MEDIUM      = 3'h6,
		OSC_OUTSIDE_HIGH_POWER  = 3'h7
	} osc_mode_e;

	typedef enum logic [1:0] {
		POLICY_OFF      = 2'h0,
		POLICY_SOFTWARE = 2'h1,
		POLICY_RUN_ONLY = 2'h2,
		POLICY_ALWAYS   = 2'h3
	} enable_policy_e;

	typedef enum logic {
		LOAD_WAIT = 1'b0,
		LOAD_DONE = 1'b1
	} load_state_e;

	// Drive strength codes shared by outside clock and crystal modes
	localparam logic [1:0] DRIVE_LOW    = 2'h0;
	localparam logic [1:0] DRIVE_MEDIUM = 2'h1;
	localparam logic [1:0] DRIVE_HIGH   = 2'h2;

endpackage : config_word_pkg

//--- osc_source_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module osc_source_decoder
(
	input  wire logic [2:0] oscillatorSelect,
	output logic            outsideClockSel,
	output logic            onChipOscSel,
	output logic            rcOscSel,
	output logic            crystalSel,
	output logic [1:0]      driveLevel,
	output logic            clockInPinIsIo
);

	config_word_pkg::osc_mode_e mode;

	assign mode = config_word_pkg::osc_mode_e'(oscillatorSelect);

	always_comb
	begin
		outsideClockSel = 1'b0;
		onChipOscSel    = 1'b0;
		rcOscSel        = 1'b0;
		crystalSel      = 1'b0;
		driveLevel      = config_word_pkg::DRIVE_LOW;
		clockInPinIsIo  = 1'b0;
		unique case (mode)
			config_word_pkg::OSC_OUTSIDE_HIGH_POWER:
			begin
				outsideClockSel = 1'b1;
				driveLevel      = config_word_pkg::DRIVE_HIGH;
			end
			config_word_pkg::OSC_OUTSIDE_MEDIUM:
			begin
				outsideClockSel = 1'b1;
				driveLevel      = config_word_pkg::DRIVE_MEDIUM;
			end
			config_word_pkg::OSC_OUTSIDE_LOW_POWER:
			begin
				outsideClockSel = 1'b1;
				driveLevel      = config_word_pkg::DRIVE_LOW;
			end
			config_word_pkg::OSC_ON_CHIP:
			begin
				onChipOscSel   = 1'b1;
				clockInPinIsIo = 1'b1;
			end
			config_word_pkg::OSC_RESISTOR_CAPACITOR:
			begin
				rcOscSel = 1'b1;
			end
			config_word_pkg::OSC_HIGH_SPEED_CRYSTAL:
			begin
				crystalSel = 1'b1;
				driveLevel = config_word_pkg::DRIVE_HIGH;
			end
			config_word_pkg::OSC_STANDARD_CRYSTAL:
			begin
				crystalSel = 1'b1;
				driveLevel = config_word_pkg::DRIVE_MEDIUM;
			end
			config_word_pkg::OSC_LOW_POWER_CRYSTAL:
			begin
				crystalSel = 1'b1;
				driveLevel = config_word_pkg::DRIVE_LOW;
			end
		endcase
	end

endmodule : osc_source_decoder

`default_nettype wire

//--- config_word_decoder_props.sv
`timescale 1ns/10ps
`default_nettype none

module config_word_decoder_props
#(
	parameter int unsigned WORD_W = 14
)
(
	input wire logic              sys_clk,
	input wire logic              rst_b,
	input wire logic [WORD_W-1:0] nvmWordOne,
	input wire logic              nvmLoadStrobe,
	input wire logic              regWrStrobe,
	input wire logic              clockOutDrive,
	input wire logic              clockOutPinIsIo,
	input wire logic              clockOutPinIsOsc,
	input wire logic              dataReadProtect,
	input wire logic              progReadProtect,
	input wire logic              powerupTimerEnable,
	input wire logic              outsideClockSel,
	input wire logic              onChipOscSel,
	input wire logic              rcOscSel,
	input wire logic              crystalSel,
	input wire logic              clockInPinIsIo
);
	// ----------------------------------------------------------------
	// Loaded word fields
	// ----------------------------------------------------------------
	logic [2:0] oscCode;
	logic       dataBit;
	logic       progBit;
	logic       pwrBit;
	assign oscCode = nvmWordOne[2:0];
	assign dataBit = nvmWordOne[8];
	assign progBit = nvmWordOne[7];
	assign pwrBit  = nvmWordOne[5];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// Load, then one quiet edge so no port write overrides the word
	sequence s_load;
		nvmLoadStrobe ##1 (!nvmLoadStrobe && !regWrStrobe);
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_crystal_pin;
		crystalSel |-> clockOutPinIsOsc && !clockOutDrive && !clockOutPinIsIo;
	endproperty
	property p_other_pin;
		(outsideClockSel || onChipOscSel || rcOscSel)
			|-> !clockOutPinIsOsc && (clockOutDrive != clockOutPinIsIo);
	endproperty
	property p_clock_input_pin_io;
		clockInPinIsIo == onChipOscSel;
	endproperty
	property p_data_prot;
		s_load |=> dataReadProtect == !$past(dataBit, 2);
	endproperty
	property p_prog_prot;
		s_load |=> progReadProtect == !$past(progBit, 2);
	endproperty
	property p_pwrup;
		s_load |=> powerupTimerEnable == !$past(pwrBit, 2);
	endproperty
	property p_outside;
		s_load |=> outsideClockSel == ($past(oscCode, 2) >= 3'h5);
	endproperty
	property p_rc;
		s_load |=> rcOscSel == ($past(oscCode, 2) == 3'h3);
	endproperty
	property p_crystal_sel;
		s_load |=> crystalSel == ($past(oscCode, 2) <= 3'h2);
	endproperty

	a_crystal_pin: assert property (p_crystal_pin)
		else $error("clock-out pin not held for the oscillator in a crystal mode");
	a_other_pin: assert property (p_other_pin)
		else $error("clock-out pin use wrong outside crystal modes");
	a_clock_input_pin_io: assert property (p_clock_input_pin_io)
		else $error("clock input pin I/O release differs from on-chip select");
	a_data_prot: assert property (p_data_prot)
		else $error("data read protection not the inverse of its bit");
	a_prog_prot: assert property (p_prog_prot)
		else $error("program read protection not the inverse of its bit");
	a_pwrup: assert property (p_pwrup)
		else $error("power-up timer enable not the inverse of its bit");
	a_outside: assert property (p_outside)
		else $error("outside clock select wrong for loaded code");
	a_rc: assert property (p_rc)
		else $error("RC oscillator select wrong for loaded code");
	a_crystal_sel: assert property (p_crystal_sel)
		else $error("crystal select wrong for loaded code");

endmodule : config_word_decoder_props

`default_nettype wire

//--- config_word_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none

module config_word_decoder_tb;
	logic        sys_clk;
	logic        rst_b;
	logic [3:0]  regAddr;
	logic [13:0] regWrData, regRdData, nvmWordOne, nvmWordTwo;
	logic        regWrStrobe, regRdStrobe, nvmLoadStrobe, coreSleep;
	logic        configReady, clockOutDrive, clockOutPinIsIo, clockOutPinIsOsc;
	logic        brownoutActive, dataReadProtect, progReadProtect, powerupTimerEnable;
	logic        watchdogRun, outsideClockSel, onChipOscSel, rcOscSel, crystalSel;
	logic        clockInPinIsIo;
	logic [1:0]  oscDriveLevel;
	wire logic [7:0] sideOut;
	int          badCount;
	int          totalChecks;

	config_word_decoder config_word_decoder_inst (
		.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.nvmWordOne(nvmWordOne), .nvmWordTwo(nvmWordTwo), .nvmLoadStrobe(nvmLoadStrobe),
		.coreSleep(coreSleep), .configReady(configReady), .clockOutDrive(clockOutDrive),
		.clockOutPinIsIo(clockOutPinIsIo), .clockOutPinIsOsc(clockOutPinIsOsc),
		.brownoutActive(brownoutActive), .dataReadProtect(dataReadProtect),
		.progReadProtect(progReadProtect), .resetPinEnable(sideOut[7]),
		.powerupTimerEnable(powerupTimerEnable), .watchdogRun(watchdogRun),
		.outsideClockSel(outsideClockSel), .onChipOscSel(onChipOscSel),
		.rcOscSel(rcOscSel), .crystalSel(crystalSel), .oscDriveLevel(oscDriveLevel),
		.clockInPinIsIo(clockInPinIsIo), .lowVoltageProgram(sideOut[6]),
		.debuggerEnable(sideOut[5]), .brownoutLevelSelect(sideOut[4]),
		.stackFaultResetEnable(sideOut[3]), .freqMultiplierEnable(sideOut[2]),
		.flashGuard(sideOut[1:0])
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : giveVerdict

	task automatic check(input string what, input logic [13:0] expV, input logic [13:0] gotV);
		totalChecks++;
		if (gotV !== expV)
		begin
			badCount++;
			$display("ERROR %s expected %h seen %h", what, expV, gotV);
		end
	endtask : check

	task automatic writeReg(input logic [3:0] a, input logic [13:0] d);
		@(posedge sys_clk);
		regAddr     <= a;
		regWrData   <= d;
		regWrStrobe <= 1'b1;
		@(posedge sys_clk);
		regWrStrobe <= 1'b0;
	endtask : writeReg

	// Data stand only in the cycle after the strobe edge
	task automatic readReg(input logic [3:0] a, output logic [13:0] d);
		@(posedge sys_clk);
		regAddr     <= a;
		regRdStrobe <= 1'b1;
		@(posedge sys_clk);
		regRdStrobe <= 1'b0;
		@(negedge sys_clk);
		d = regRdData;
	endtask : readReg

	task automatic settle;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	task automatic load(input logic [13:0] w1, input logic [13:0] w2);
		@(posedge sys_clk);
		nvmWordOne    <= w1;
		nvmWordTwo    <= w2;
		nvmLoadStrobe <= 1'b1;
		@(posedge sys_clk);
		nvmLoadStrobe <= 1'b0;
		settle();
	endtask : load

	initial
	begin
		#1000000;
		badCount++;
		giveVerdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [2:0]  code;
		logic        cry, act;
		logic [1:0]  lvl;
		logic [13:0] d, w1, w2;
		badCount = 0;
		totalChecks = 0;
		rst_b = 1'b0;
		regAddr = 4'h0;
		regWrData = 14'h0000;
		regWrStrobe = 1'b0;
		regRdStrobe = 1'b0;
		nvmWordOne = 14'h3FFF;
		nvmWordTwo = 14'h3FFF;
		nvmLoadStrobe = 1'b0;
		coreSleep = 1'b0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		// Every oscillator code with the clock-out bit both ways
		for (int c = 0; c < 16; c++)
		begin
			code = c[2:0];
			cry = (code <= 3'h2);
			lvl = cry ? code[1:0] : (code >= 3'h5) ? 2'(code - 3'h5) : 2'h0;
			load(14'h37F8 | {c[3], 11'h000} | {11'h000, code}, 14'h3FFF);
			check("clock source", 14'({code >= 3'h5, code == 3'h4, code == 3'h3, cry, lvl,
				code == 3'h4, !cry && !c[3], !cry && c[3], cry}),
				14'({outsideClockSel, onChipOscSel, rcOscSel, crystalSel, oscDriveLevel,
				clockInPinIsIo, clockOutDrive, clockOutPinIsIo, clockOutPinIsOsc}));
		end
		// Every enable policy against software bit and Sleep
		for (int p = 0; p < 4; p++)
		begin
			load(14'h39E7 | {3'h0, 2'(p), 9'h000} | {9'h000, 2'(p), 3'h0}, 14'h3FFF);
			for (int s = 0; s < 4; s++)
			begin
				writeReg(config_word_pkg::REG_BROWNOUT, 14'(s & 1));
				writeReg(config_word_pkg::REG_WATCHDOG, 14'(s & 1));
				@(posedge sys_clk);
				coreSleep <= s[1];
				settle();
				act = (p == 3) || (p == 2 && !s[1]) || (p == 1 && s[0]);
				check("brownout active", 14'(act), 14'(brownoutActive));
				check("watchdog run", 14'(act), 14'(watchdogRun));
				readReg(config_word_pkg::REG_STATUS, d);
				check("status enables", 14'({act, act}), 14'(d[1:0]));
			end
		end
		@(posedge sys_clk);
		coreSleep <= 1'b0;
		// Protection and power-up timer bits
		for (int k = 0; k < 8; k++)
		begin
			w1 = 14'h3E5F | {5'h00, k[2], k[1], 1'b0, k[0], 5'h00};
			w2 = 14'(k * 14'h0911);
			load(w1, w2);
			check("data protect", 14'(!k[2]), 14'(dataReadProtect));
			check("program protect", 14'(!k[1]), 14'(progReadProtect));
			check("power-up timer", 14'(!k[0]), 14'(powerupTimerEnable));
			check("loaded fields", 14'({1'b1, w1[6], w2[13], !w2[12], w2[10:8], w2[1:0]}),
				14'({configReady, sideOut}));
			readReg(config_word_pkg::REG_STATUS, d);
			check("status protect", 14'({!k[0], !k[1], !k[2]}), 14'(d[4:2]));
			readReg(config_word_pkg::REG_WORD_ONE, d);
			check("word one", w1, d);
			readReg(config_word_pkg::REG_WORD_TWO, d);
			check("word two", w2 | config_word_pkg::WORD_TWO_ONES, d);
		end
		readReg(4'h9, d);
		check("unmapped read", 14'h0000, d);
		// Programming path over the register port
		writeReg(config_word_pkg::REG_WORD_ONE, 14'h3FFC);
		settle();
		check("on-chip select", 14'h0003, 14'({onChipOscSel, clockInPinIsIo}));
		giveVerdict();
	end

endmodule : config_word_decoder_tb

bind config_word_decoder config_word_decoder_props #(.WORD_W(WORD_W)) config_word_decoder_props_inst (
	.sys_clk(sys_clk), .rst_b(rst_b), .nvmWordOne(nvmWordOne), .nvmLoadStrobe(nvmLoadStrobe),
	.regWrStrobe(regWrStrobe), .clockOutDrive(clockOutDrive), .clockOutPinIsIo(clockOutPinIsIo),
	.clockOutPinIsOsc(clockOutPinIsOsc), .dataReadProtect(dataReadProtect),
	.progReadProtect(progReadProtect), .powerupTimerEnable(powerupTimerEnable),
	.outsideClockSel(outsideClockSel), .onChipOscSel(onChipOscSel), .rcOscSel(rcOscSel),
	.crystalSel(crystalSel), .clockInPinIsIo(clockInPinIsIo)
);

`default_nettype wire
